// ==== pciow_pkg.sv ====
// Constants, field layouts and carrier types of the I/O window setup block.
// Assumes one 100 MHz host-side clock; byte-wide socket register port.
package pciow_pkg;

   // Socket register byte offsets
   localparam logic [7:0] OFF_WIN_EN = 8'h06;
   localparam logic [7:0] OFF_CTRL = 8'h07;
   localparam logic [7:0] OFF_W0_START_LO = 8'h08;
   localparam logic [7:0] OFF_W0_START_HI = 8'h09;
   localparam logic [7:0] OFF_W0_END_LO = 8'h0a;
   localparam logic [7:0] OFF_W0_END_HI = 8'h0b;
   localparam logic [7:0] OFF_W1_START_LO = 8'h0c;
   localparam logic [7:0] OFF_W1_START_HI = 8'h0d;
   localparam logic [7:0] OFF_W1_END_LO = 8'h0e;
   localparam logic [7:0] OFF_W1_END_HI = 8'h0f;
   // Offset step between window 0 and window 1 address registers
   localparam logic [7:0] OFF_WIN_STEP = 8'h04;

   // Window enable register fields
   localparam int BIT_IO_WIN0_ON = 6;
   localparam int BIT_EN_RSVD = 5;

   // Timing and sizing control fields, window n at bit 4*n + field
   localparam int CTRL_FIELD_W = 4;
   localparam int BIT_FIXED_WIDTH = 0;
   localparam int BIT_AUTO_SIZING = 1;
   localparam int BIT_SHORT_CYCLE = 2;
   localparam int BIT_EXTRA_WAIT = 3;

   // Values after reset
   localparam logic [7:0] RST_WIN_EN = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_ADDR = 8'h00;

   // Cycle timing in ISA-equivalent cycles
   localparam int CLK_PERIOD_NS = 10;
   localparam int ISA_CYCLE_NS = 125;
   localparam int ISA_CLKS = (ISA_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STD8_ISA = 4'h6;
   localparam logic [3:0] STD16_ISA = 4'h3;
   localparam logic [3:0] SHORT8_ISA = 4'h3;
   localparam logic [3:0] EXTRA_WAIT_ISA = 4'h1;

   // Per-window setup as seen by the address matcher
   typedef struct packed {
      logic on;
      logic [15:0] start;
      logic [15:0] stop;
      logic extra_wait;
      logic short_cycle;
      logic auto_sizing;
      logic fixed_width;
   } pciow_win_cfg_s;

   // Per-window decision for the current host address
   typedef struct packed {
      logic hit;
      logic wide;
      logic [3:0] isa_cycles;
   } pciow_win_res_s;

   typedef enum logic [1:0] {
      CYC_IDLE = 2'b00,
      CYC_RUN = 2'b01
   } pciow_cyc_state_e;

endpackage : pciow_pkg

// ==== pciow_win_match.sv ====
// Address match, data width and cycle length for one I/O window.
// Assumes the card width signal is already synchronised to ref_clk_in.
`timescale 1ns/10ps
module pciow_win_match (
   // Window setup
   input wire pciow_pkg::pciow_win_cfg_s cfg_in,
   // Host cycle
   input wire logic [15:0] addr_in,
   input wire logic card_wide_in,
   // Decision
   output pciow_pkg::pciow_win_res_s res_out
);

   logic wide;

   // Auto sizing overrides the fixed width bit
   assign wide = cfg_in.auto_sizing ? card_wide_in : cfg_in.fixed_width;

   // Only an enabled window claims an address in its inclusive range
   always_comb
   begin
      res_out.hit = cfg_in.on && (addr_in >= cfg_in.start)
                    && (addr_in <= cfg_in.stop);
      res_out.wide = wide;
      // Wait bit touches only 16-bit, short bit only 8-bit cycles
      if (wide)
      begin
         res_out.isa_cycles = cfg_in.extra_wait
            ? pciow_pkg::STD16_ISA + pciow_pkg::EXTRA_WAIT_ISA
            : pciow_pkg::STD16_ISA;
      end
      else
      begin
         res_out.isa_cycles = cfg_in.short_cycle
            ? pciow_pkg::SHORT8_ISA : pciow_pkg::STD8_ISA;
      end
   end

endmodule : pciow_win_match

// ==== pciow_io_window_setup.sv ====
// I/O window setup of the 16-bit card socket: registers and cycle timer.
// Assumes host register and I/O requests come from logic on ref_clk_in;
// the card width pin is asynchronous and is synchronised here.
// How it works
// - Window 1 wait bit adds one ISA wait state to 16-bit cycles only.
// - Window 1 short bit cuts 8-bit cycles to three ISA cycles.
// - Window 1 auto sizing takes width from card pin, else fixed bit.
// - Window 1 fixed width bit: 0 is 8 bits, 1 is 16 bits.
// - Window 0 wait bit adds one ISA wait state to 16-bit cycles.
// - Window 0 short bit cuts 8-bit cycles to three ISA cycles.
// - Window 0 auto sizing takes width from card pin, else fixed bit.
// - Window 0 fixed width bit: 0 is 8 bits, 1 is 16 bits.
// - Control register at 07h, read/write, clears to 00h.
// - Start low bytes at 08h and 0Ch, read/write, reset zero.
// - Start high bytes at 09h and 0Dh, read/write, reset zero.
// - Window claims no host cycle unless its enable bit at 06h is set.
// - End addresses at 0Ah/0Bh and 0Eh/0Fh.
`timescale 1ns/10ps
module pciow_io_window_setup (
   // Clock, reset, enable
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // Socket register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // Host I/O cycle
   input wire logic io_req_in,
   input wire logic [15:0] io_addr_in,
   output logic io_claim_out,
   output logic io_win_out,
   output logic io_wide_out,
   output logic io_done_out,
   // Card pin
   input wire logic card_iois16_in
);

   localparam logic [6:0] ISA_CLKS_W = 7'(pciow_pkg::ISA_CLKS);

   logic [7:0] win_en_r, win_en_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [1:0][15:0] start_r, start_nxt;
   logic [1:0][15:0] stop_r, stop_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] iois_sync_r;
   pciow_pkg::pciow_cyc_state_e state_r, state_nxt;
   logic [6:0] cnt_r, cnt_nxt;
   logic claim_r, claim_nxt;
   logic win_r, win_nxt;
   logic wide_r, wide_nxt;
   logic done_r, done_nxt;
   pciow_pkg::pciow_win_cfg_s [1:0] cfg;
   pciow_pkg::pciow_win_res_s [1:0] res;
   logic card_wide;

   // Card pin passes two flops before anything looks at it
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
         iois_sync_r <= 2'h0;
      else if (ce_in)
         iois_sync_r <= {iois_sync_r[0], card_iois16_in};
   end
   assign card_wide = iois_sync_r[1];

   // Register writes and registered read data
   always_comb
   begin
      win_en_nxt = win_en_r;
      ctrl_nxt = ctrl_r;
      start_nxt = start_r;
      stop_nxt = stop_r;
      rdata_nxt = rdata_r;
      rvalid_nxt = reg_rd_in;
      if (reg_wr_in)
      begin
         unique case (reg_addr_in)
            pciow_pkg::OFF_WIN_EN:
            begin
               win_en_nxt = reg_wdata_in;
               win_en_nxt[pciow_pkg::BIT_EN_RSVD] = 1'b0; // Reads as zero
            end
            pciow_pkg::OFF_CTRL: ctrl_nxt = reg_wdata_in;
            pciow_pkg::OFF_W0_START_LO: start_nxt[0][7:0] = reg_wdata_in;
            pciow_pkg::OFF_W0_START_HI: start_nxt[0][15:8] = reg_wdata_in;
            pciow_pkg::OFF_W0_END_LO: stop_nxt[0][7:0] = reg_wdata_in;
            pciow_pkg::OFF_W0_END_HI: stop_nxt[0][15:8] = reg_wdata_in;
            pciow_pkg::OFF_W1_START_LO: start_nxt[1][7:0] = reg_wdata_in;
            pciow_pkg::OFF_W1_START_HI: start_nxt[1][15:8] = reg_wdata_in;
            pciow_pkg::OFF_W1_END_LO: stop_nxt[1][7:0] = reg_wdata_in;
            pciow_pkg::OFF_W1_END_HI: stop_nxt[1][15:8] = reg_wdata_in;
            default: ; // Other socket offsets belong elsewhere
         endcase
      end
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            pciow_pkg::OFF_WIN_EN: rdata_nxt = win_en_r;
            pciow_pkg::OFF_CTRL: rdata_nxt = ctrl_r;
            pciow_pkg::OFF_W0_START_LO: rdata_nxt = start_r[0][7:0];
            pciow_pkg::OFF_W0_START_HI: rdata_nxt = start_r[0][15:8];
            pciow_pkg::OFF_W0_END_LO: rdata_nxt = stop_r[0][7:0];
            pciow_pkg::OFF_W0_END_HI: rdata_nxt = stop_r[0][15:8];
            pciow_pkg::OFF_W1_START_LO: rdata_nxt = start_r[1][7:0];
            pciow_pkg::OFF_W1_START_HI: rdata_nxt = start_r[1][15:8];
            pciow_pkg::OFF_W1_END_LO: rdata_nxt = stop_r[1][7:0];
            pciow_pkg::OFF_W1_END_HI: rdata_nxt = stop_r[1][15:8];
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         win_en_r <= pciow_pkg::RST_WIN_EN;
         ctrl_r <= pciow_pkg::RST_CTRL;
         start_r <= {4{pciow_pkg::RST_ADDR}};
         stop_r <= {4{pciow_pkg::RST_ADDR}};
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end
      else if (ce_in)
      begin
         win_en_r <= win_en_nxt;
         ctrl_r <= ctrl_nxt;
         start_r <= start_nxt;
         stop_r <= stop_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end
   assign reg_rdata_out = rdata_r;
   assign reg_rvalid_out = rvalid_r;

   // One matcher per window, each with its own control nibble
   generate
      for (genvar w = 0; w < 2; w++)
      begin : g_win
         localparam int B = w * pciow_pkg::CTRL_FIELD_W;
         always_comb
         begin
            cfg[w].on = win_en_r[pciow_pkg::BIT_IO_WIN0_ON + w];
            cfg[w].start = start_r[w];
            cfg[w].stop = stop_r[w];
            cfg[w].extra_wait = ctrl_r[B + pciow_pkg::BIT_EXTRA_WAIT];
            cfg[w].short_cycle = ctrl_r[B + pciow_pkg::BIT_SHORT_CYCLE];
            cfg[w].auto_sizing = ctrl_r[B + pciow_pkg::BIT_AUTO_SIZING];
            cfg[w].fixed_width = ctrl_r[B + pciow_pkg::BIT_FIXED_WIDTH];
         end
         pciow_win_match u_match (
            .cfg_in(cfg[w]),
            .addr_in(io_addr_in),
            .card_wide_in(card_wide),
            .res_out(res[w])
         );
      end
   endgenerate

   // Cycle timer; window 0 wins when both windows overlap
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      claim_nxt = claim_r;
      win_nxt = win_r;
      wide_nxt = wide_r;
      done_nxt = 1'b0;
      unique case (state_r)
         pciow_pkg::CYC_IDLE:
         begin
            if (io_req_in && (res[0].hit || res[1].hit))
            begin
               win_nxt = !res[0].hit;
               wide_nxt = res[0].hit ? res[0].wide : res[1].wide;
               cnt_nxt = 7'((res[0].hit ? res[0].isa_cycles
                  : res[1].isa_cycles) * ISA_CLKS_W - 7'h01);
               claim_nxt = 1'b1;
               state_nxt = pciow_pkg::CYC_RUN;
            end
         end
         pciow_pkg::CYC_RUN:
         begin
            if (cnt_r == 7'h00)
            begin
               claim_nxt = 1'b0;
               done_nxt = 1'b1;
               state_nxt = pciow_pkg::CYC_IDLE;
            end
            else
               cnt_nxt = cnt_r - 7'h01;
         end
         default: state_nxt = pciow_pkg::CYC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= pciow_pkg::CYC_IDLE;
         cnt_r <= 7'h00;
         claim_r <= 1'b0;
         win_r <= 1'b0;
         wide_r <= 1'b0;
         done_r <= 1'b0;
      end
      else if (ce_in)
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         claim_r <= claim_nxt;
         win_r <= win_nxt;
         wide_r <= wide_nxt;
         done_r <= done_nxt;
      end
   end
   assign io_claim_out = claim_r;
   assign io_win_out = win_r;
   assign io_wide_out = wide_r;
   assign io_done_out = done_r;

   // Checks; they assume ce_in stays high while they run
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in || !ce_in);

   // Helper: claimed length and the length the bits ask for
   logic [6:0] len_r;
   logic [6:0] exp_r;
   logic [3:0] exp_isa;
   always_comb
   begin
      if (wide_r)
         exp_isa = ctrl_r[{win_r, 2'h3}] ? 4'h4 : 4'h3;
      else
         exp_isa = ctrl_r[{win_r, 2'h2}] ? 4'h3 : 4'h6;
   end
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || !claim_r)
         len_r <= 7'h00;
      else if (ce_in)
         len_r <= len_r + 7'h01; // Frozen with the timer when enable is low
      exp_r <= 7'(exp_isa * 4'hd);
   end

   sequence s_req_w0;
      state_r == pciow_pkg::CYC_IDLE && io_req_in && res[0].hit;
   endsequence

   a_len_match: assert property (
      $fell(claim_r) |-> len_r == exp_r)
      else $error("Claimed cycle length does not match timing bits");
   a_short_eight: assert property (
      s_req_w0 ##1 (!wide_r && ctrl_r[2] && !win_r) |->
      claim_r [*8] ##31 (claim_r && !io_done_out) ##1 !claim_r)
      else $error("Short 8-bit window 0 cycle is not three ISA cycles");
   a_w0_width: assert property (
      s_req_w0 |=> io_wide_out == ($past(ctrl_r[1]) ? $past(card_wide)
                                   : $past(ctrl_r[0])))
      else $error("Window 0 width not taken from the selected source");
   a_w1_width: assert property (
      state_r == pciow_pkg::CYC_IDLE && io_req_in && !res[0].hit
      && res[1].hit |=> io_win_out && io_wide_out ==
      ($past(ctrl_r[5]) ? $past(card_wide) : $past(ctrl_r[4])))
      else $error("Window 1 width not taken from the selected source");
   a_off_no_claim: assert property (
      state_r == pciow_pkg::CYC_IDLE && io_req_in && !win_en_r[6]
      && !win_en_r[7] |=> !io_claim_out)
      else $error("Cycle claimed with both I/O windows disabled");
   a_range_claim: assert property (
      state_r == pciow_pkg::CYC_IDLE && io_req_in && win_en_r[6]
      && io_addr_in >= start_r[0] && io_addr_in <= stop_r[0]
      |=> io_claim_out && !io_win_out)
      else $error("Address inside enabled window 0 was not claimed");
   a_ctrl_write: assert property (
      reg_wr_in && reg_addr_in == 8'h07 |=>
      ctrl_r == $past(reg_wdata_in) ##1 1'b1)
      else $error("Control register did not take the written byte");
   a_start_read: assert property (
      reg_rd_in && !reg_wr_in && reg_addr_in == 8'h0d |=>
      reg_rvalid_out && reg_rdata_out == start_r[1][15:8])
      else $error("Window 1 start high byte read back wrong");
   a_start_lo_write: assert property (
      reg_wr_in && reg_addr_in == 8'h08 |=>
      start_r[0][7:0] == $past(reg_wdata_in))
      else $error("Window 0 start low byte did not take the write");
   a_end_write: assert property (
      reg_wr_in && reg_addr_in == 8'h0f |=>
      stop_r[1][15:8] == $past(reg_wdata_in))
      else $error("Window 1 end high byte did not take the write");

endmodule : pciow_io_window_setup

// ==== pciow_card_model.sv ====
// Behavioural 16-bit card in the socket: drives the card width pin.
// Assumes the bench chooses the card's data width as a plain level.
`timescale 1ns/10ps
module pciow_card_model (
   // Card setup chosen by the bench
   input wire logic wide_mode_in,
   // Card pin
   output logic card_iois16_out
);
   // Pin moves off the host clock grid, so the synchroniser is exercised
   assign #3 card_iois16_out = wide_mode_in;
endmodule : pciow_card_model

// ==== tb.sv ====
// Self-checking bench of the I/O window setup block with a card model.
// Assumes 1-cycle read latency and 13 clocks per ISA cycle.
`timescale 1ns/10ps
module tb;
   logic ref_clk_in, rst_n_in, ce_in, reg_wr_in, reg_rd_in, io_req_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d, seed;
   logic [15:0] io_addr_in;
   logic reg_rvalid_out, io_claim_out, io_win_out, io_wide_out, io_done_out;
   logic card_iois16, card_wide, win, wide, done;
   logic [3:0] nib, nib1;
   logic [15:0] got;
   int err_count, num_checks, a, n, cyc;
   int regs[256];

   pciow_io_window_setup pciow_io_window_setup_inst (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .io_req_in(io_req_in), .io_addr_in(io_addr_in),
      .io_claim_out(io_claim_out), .io_win_out(io_win_out),
      .io_wide_out(io_wide_out), .io_done_out(io_done_out),
      .card_iois16_in(card_iois16));

   pciow_card_model pciow_card_model_inst (
      .wide_mode_in(card_wide), .card_iois16_out(card_iois16));

   // Free-running 100 MHz clock
   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // Expected width: auto sizing follows the card pin, else the fixed bit
   function automatic logic exp_w(input logic [3:0] f, input logic pin);
      return f[1] ? pin : f[0];
   endfunction : exp_w

   // Expected length in clocks, 13 per ISA cycle: 16-bit 3 (+1 wait), 8-bit 6 or 3 short
   function automatic int exp_n(input logic [3:0] f, input logic pin);
      if (exp_w(f, pin))
         return (3 + int'(f[3])) * pciow_pkg::ISA_CLKS;
      return (f[2] ? 3 : 6) * pciow_pkg::ISA_CLKS;
   endfunction : exp_n

   task stop_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Model keeps mapped offsets only; the reserved enable bit stays 0
   task reg_wr(input logic [7:0] ad, input logic [7:0] wd);
      @(posedge ref_clk_in);
      #1;
      reg_wr_in = 1'b1;
      reg_addr_in = ad;
      reg_wdata_in = wd;
      @(posedge ref_clk_in);
      #1;
      reg_wr_in = 1'b0;
      reg_wdata_in = ~wd;
      // A write while the clock enable is low must not land
      if (ce_in && ad >= 8'h06 && ad <= 8'h0f)
         regs[ad] = (ad == 8'h06) ? int'(wd & 8'hdf) : int'(wd);
   endtask : reg_wr

   // A missing valid pulse yields unknown data, so the compare fails
   task reg_rd(input logic [7:0] ad, output logic [7:0] rd);
      int i;
      @(posedge ref_clk_in);
      #1;
      reg_rd_in = 1'b1;
      reg_addr_in = ad;
      @(posedge ref_clk_in);
      #1;
      reg_rd_in = 1'b0;
      for (i = 0; i < 3 && reg_rvalid_out !== 1'b1; i++)
      begin
         @(posedge ref_clk_in);
         #1;
      end
      rd = (reg_rvalid_out === 1'b1) ? reg_rdata_out : 8'hxx;
   endtask : reg_rd

   // One host request; counts clocks of claim and samples done after it
   task io_run(input logic [15:0] ad);
      int i;
      cyc = 0;
      win = 1'bx;
      wide = 1'bx;
      @(posedge ref_clk_in);
      #1;
      io_req_in = 1'b1;
      io_addr_in = ad;
      @(posedge ref_clk_in);
      #1;
      io_req_in = 1'b0;
      io_addr_in = ~ad;
      for (i = 0; i < 120; i++)
      begin
         if (io_claim_out === 1'b1)
         begin
            if (cyc == 0)
            begin
               win = io_win_out;
               wide = io_wide_out;
            end
            cyc++;
         end
         else if (cyc > 0 || i > 3)
            break;
         @(posedge ref_clk_in);
         #1;
      end
      done = io_done_out;
   endtask : io_run

   // Main sequence
   initial
   begin
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      io_req_in = 1'b0;
      io_addr_in = 16'h0000;
      card_wide = 1'b0;
      seed = 8'h5b;
      repeat (4) @(posedge ref_clk_in);
      #1;
      rst_n_in = 1'b1;
      for (a = 5; a <= 16; a++)
      begin
         reg_rd(8'(a), d);
         chk(16'(d), 16'h0000);
      end
      for (a = 5; a <= 16; a++)
      begin
         seed = lfsr(seed);
         reg_wr(8'(a), seed);
      end
      for (a = 5; a <= 16; a++)
      begin
         reg_rd(8'(a), d);
         chk(16'(d), 16'(regs[a]));
      end
      // Window 0 at 0100h..01ffh, window 1 at 0200h..02ffh, both on
      reg_wr(8'h08, 8'h00);
      reg_wr(8'h09, 8'h01);
      reg_wr(8'h0a, 8'hff);
      reg_wr(8'h0b, 8'h01);
      reg_wr(8'h0c, 8'h00);
      reg_wr(8'h0d, 8'h02);
      reg_wr(8'h0e, 8'hff);
      reg_wr(8'h0f, 8'h02);
      reg_wr(8'h06, 8'hc0);
      // Every field setting of both windows, card narrow and wide
      for (n = 0; n < 32; n++)
      begin
         nib = n[3:0];
         nib1 = 4'hf - nib;
         card_wide = n[4];
         reg_wr(8'h07, {nib1, nib});
         repeat (4) @(posedge ref_clk_in);
         io_run(n[0] ? 16'h01ff : 16'h0100);
         got = {13'h0, win, wide, done};
         chk(got, {14'h0, exp_w(nib, n[4]), 1'b1});
         chk(16'(cyc), 16'(exp_n(nib, n[4])));
         io_run(n[0] ? 16'h0200 : 16'h02ff);
         got = {13'h0, win, wide, done};
         chk(got, {14'h1, exp_w(nib1, n[4]), 1'b1});
         chk(16'(cyc), 16'(exp_n(nib1, n[4])));
      end
      // Just outside both windows: no claim
      io_run(16'h00ff);
      chk({15'(cyc), done}, 16'h0000);
      io_run(16'h0300);
      chk({15'(cyc), done}, 16'h0000);
      // Window 0 switched off, then window 1 switched off
      reg_wr(8'h06, 8'h80);
      seed = lfsr(seed);
      io_run({8'h01, seed});
      chk(16'(cyc), 16'h0);
      io_run({8'h02, seed});
      chk({14'h0, win, done}, 16'h0003);
      reg_wr(8'h06, 8'h40);
      io_run({8'h02, seed});
      chk(16'(cyc), 16'h0);
      // Both windows off: nothing is claimed
      reg_wr(8'h06, 8'h00);
      io_run(16'h0100);
      chk({15'(cyc), done}, 16'h0000);
      // Clock enable low freezes the control register
      ce_in = 1'b0;
      reg_wr(8'h07, 8'h5a);
      ce_in = 1'b1;
      reg_rd(8'h07, d);
      chk(16'(d), 16'(regs[7]));
      stop_test;
   end

   // Watchdog: the sequence needs well under 10000 clocks
   initial
   begin
      #500000;
      err_count++;
      stop_test;
   end
endmodule : tb
